// ==== design/mfsc_stats.sv ====
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mfsc_stats
    import mfsc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // receive frame status
    input wire logic i_rx_valid,
    input wire mfsc_pkg::mfsc_rx_status_s i_rx_status,
    input wire logic i_rx_active,
    input wire logic i_rx_error_input,
    output logic o_rx_code_discard,
    // transmit frame status
    input wire logic i_tx_valid,
    input wire mfsc_pkg::mfsc_tx_status_s i_tx_status,
    // pause generation
    input wire logic i_pause_req,
    output logic o_pause_send,
    // interrupt level
    output logic o_stats_irq_pending
);
    import mfsc_pkg::*;

    typedef struct packed {
        logic [NCNT-1:0][CW-1:0] cnt;
        logic media_if_enable;
        logic fdx;
        logic irq_en;
        logic rx_qos_filter_enable;
        logic [LW-1:0] rx_max_frame_length;
        logic [5:0] clr_cnt;
        logic done;
        logic wr;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic sync1;
        logic sync2;
        logic code;
        logic irq;
    } mfsc_state_s;

    mfsc_state_s st_q;
    mfsc_state_s st_d;
    logic [NCNT-1:0][CW-1:0] inc;
    logic err_hit;
    logic code_err;
    logic align_err;
    logic crc_err;
    logic bad;
    logic inrng;
    logic too_long;
    logic too_short;
    logic tx_good;
    logic ap;
    logic any_top;

    function automatic logic [CW-1:0] sat_sub(input logic [CW-1:0] a, input logic [CW-1:0] b);
        sat_sub = (b > a) ? '0 : a - b;
    endfunction

    function automatic logic [CW-1:0] one_if(input logic c);
        one_if = {{(CW-1){1'b0}}, c};
    endfunction

    // frame classification
    always_comb
    begin
        err_hit = i_rx_active & st_q.sync2;
        code_err = st_q.code | err_hit;
        align_err = i_rx_status.odd_nibbles & i_rx_status.fcs_fail_trunc;
        crc_err = ~i_rx_status.odd_nibbles & i_rx_status.fcs_fail;
        bad = crc_err | align_err | code_err;
        too_long = i_rx_status.len > st_q.rx_max_frame_length;
        too_short = i_rx_status.len < MIN_LEN;
        inrng = ~too_long & ~too_short;
        tx_good = ~i_tx_status.late_coll & ~i_tx_status.excess_coll
            & ~i_tx_status.carrier_loss & ~i_tx_status.underrun;
        ap = i_hsel & i_htrans[1] & i_hready;
    end

    always_comb
    begin
        inc = '0;
        if (i_rx_valid)
        begin
            // one increment even when both error kinds are present
            inc[IX_ALIGN] = one_if(i_rx_status.addr_ok & inrng & (align_err | code_err));
            inc[IX_LONG] = one_if(i_rx_status.addr_ok & too_long & ~bad);
            inc[IX_LBAD] = one_if(i_rx_status.addr_ok & too_long & bad);
            inc[IX_SHORT] = one_if(i_rx_status.addr_ok & ~i_rx_status.ctrl_frame
                & too_short & ~bad);
            inc[IX_SBAD] = one_if(~i_rx_status.ctrl_frame & too_short & bad
                & ~i_rx_status.coll_fc_frag);
            inc[IX_REJ] = one_if(~i_rx_status.addr_ok & ~i_rx_status.ctrl_frame & ~bad);
            inc[IX_QOS] = one_if(i_rx_status.addr_ok & ~bad & inrng & st_q.rx_qos_filter_enable
                & (i_rx_status.flow_threshold >= i_rx_status.free_buffer_count));
            if (i_rx_status.addr_ok & inrng & ~bad)
            begin
                inc[IX_OCT] = {{(CW-LW){1'b0}}, i_rx_status.len};
            end
            // overruns look at no error bit and block nothing else, except that sof_ovr blocks the mof_ovr count
            inc[IX_SOF] = one_if(i_rx_status.addr_ok & i_rx_status.sof_ovr);
            inc[IX_MOF] = one_if(i_rx_status.addr_ok & i_rx_status.mof_ovr
                & ~i_rx_status.sof_ovr);
            inc[IX_DMA] = one_if(i_rx_status.addr_ok & i_rx_status.dma_zero_hdp);
            inc[IX_F64] = one_if(i_rx_status.addr_ok & (i_rx_status.len == MIN_LEN));
        end
        if (i_tx_valid)
        begin
            inc[IX_TXG] = one_if(tx_good);
            inc[IX_TXB] = one_if(tx_good & i_tx_status.bcast);
            inc[IX_TXM] = one_if((tx_good & i_tx_status.mcast & ~i_tx_status.bcast)
                | i_tx_status.hw_pause);
            inc[IX_PAUSE] = one_if(i_tx_status.hw_pause);
            inc[IX_F64] = inc[IX_F64] + one_if(((i_tx_status.len == MIN_LEN) & tx_good)
                | i_tx_status.hw_pause);
        end
    end

    always_comb
    begin
        st_d = st_q;
        st_d.sync1 = i_rx_error_input;
        st_d.sync2 = st_q.sync1;
        // a hit in the closing cycle belongs to the next frame, so set wins
        st_d.code = (i_rx_valid ? 1'b0 : st_q.code) | err_hit;
        for (int i = 0; i < NCNT; i++)
        begin
            st_d.cnt[i] = st_q.cnt[i] + inc[i];
        end
        if (st_q.wr)
        begin
            if (st_q.addr[7:6] == 2'h0)
            begin
                if (st_q.media_if_enable)
                begin
                    st_d.cnt[st_q.addr[5:2]] = sat_sub(st_d.cnt[st_q.addr[5:2]], i_hwdata);
                end
                else
                begin
                    st_d.cnt[st_q.addr[5:2]] = i_hwdata;
                end
            end
            else
            begin
                case (st_q.addr)
                    ADDR_MAC_CTRL:
                    begin
                        st_d.media_if_enable = i_hwdata[MIF_BIT];
                        st_d.fdx = i_hwdata[FDX_BIT];
                        st_d.irq_en = i_hwdata[IRQEN_BIT];
                    end
                    ADDR_RX_ACCEPT:
                    begin
                        st_d.rx_qos_filter_enable = i_hwdata[QOS_BIT];
                    end
                    ADDR_MAX_LEN:
                    begin
                        st_d.rx_max_frame_length = i_hwdata[LW-1:0];
                    end
                    default:
                    begin
                        st_d.addr = st_q.addr;
                    end
                endcase
            end
        end
        // counters hold zero until the clear delay has run out
        if (!st_q.done)
        begin
            st_d.cnt = '0;
            st_d.clr_cnt = st_q.clr_cnt + 6'h1;
            st_d.done = (st_q.clr_cnt == CLR_LAST);
        end
        any_top = 1'b0;
        for (int i = 0; i < NCNT; i++)
        begin
            any_top = any_top | st_d.cnt[i][CW-1];
        end
        st_d.irq = st_d.irq_en & any_top;
        // sub-word writes are dropped, software must write whole words
        st_d.wr = ap & i_hwrite & (i_hsize == HSIZE_WORD);
        st_d.addr = ap ? i_haddr[7:0] : st_q.addr;
        if (ap & ~i_hwrite)
        begin
            if (i_haddr[7:6] == 2'h0)
            begin
                st_d.rdata = st_d.cnt[i_haddr[5:2]];
            end
            else
            begin
                st_d.rdata = '0;
                case (i_haddr[7:0])
                    ADDR_MAC_CTRL:
                    begin
                        st_d.rdata[MIF_BIT] = st_d.media_if_enable;
                        st_d.rdata[FDX_BIT] = st_d.fdx;
                        st_d.rdata[IRQEN_BIT] = st_d.irq_en;
                    end
                    ADDR_RX_ACCEPT:
                    begin
                        st_d.rdata[QOS_BIT] = st_d.rx_qos_filter_enable;
                    end
                    ADDR_MAX_LEN:
                    begin
                        st_d.rdata[LW-1:0] = st_d.rx_max_frame_length;
                    end
                    ADDR_STATUS:
                    begin
                        st_d.rdata[PEND_BIT] = st_q.irq;
                        st_d.rdata[DONE_BIT] = st_q.done;
                        st_d.rdata[CODE_BIT] = st_q.code;
                    end
                    default:
                    begin
                        st_d.rdata = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            st_q <= '0;
            st_q.rx_max_frame_length <= MAX_LEN_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = st_q.rdata;
    assign o_rx_code_discard = st_q.code;
    assign o_stats_irq_pending = st_q.irq;
    assign o_pause_send = i_pause_req & st_q.fdx;

    // quiet: cleared and no register write landing this cycle
    logic quiet;
    assign quiet = st_q.done & ~st_q.wr;

    // top bit of every counter, for the interrupt check
    logic [NCNT-1:0] top_bits;
    always_comb
    begin
        for (int i = 0; i < NCNT; i++)
        begin
            top_bits[i] = st_q.cnt[i][CW-1];
        end
    end

    clear_delay_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (!st_q.done && st_q.clr_cnt == CLR_LAST) |=> st_q.done && st_q.cnt == '0)
        else $error("counters not cleared after delay");
    align_once_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_rx_valid && i_rx_status.addr_ok && inrng && align_err && code_err)
        |=> st_q.cnt[IX_ALIGN] == $past(st_q.cnt[IX_ALIGN]) + 32'h1)
        else $error("align/code count not one");
    code_mark_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_rx_active && st_q.sync2 && !i_rx_valid) |=> o_rx_code_discard)
        else $error("code error not marked");
    long_bad_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_rx_valid && i_rx_status.addr_ok && too_long && bad)
        |=> st_q.cnt[IX_LBAD] != $past(st_q.cnt[IX_LBAD])
            && st_q.cnt[IX_LONG] == $past(st_q.cnt[IX_LONG]))
        else $error("long bad frame miscounted");
    short_bad_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_rx_valid && too_short && bad && !i_rx_status.ctrl_frame
            && i_rx_status.coll_fc_frag)
        |=> st_q.cnt[IX_SBAD] == $past(st_q.cnt[IX_SBAD]))
        else $error("flow control fragment counted");
    octet_sum_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_rx_valid && i_rx_status.addr_ok && inrng && !bad)
        |=> st_q.cnt[IX_OCT] == $past(st_q.cnt[IX_OCT]) + {16'h0000, $past(i_rx_status.len)})
        else $error("octets not added");
    overrun_free_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_rx_valid && i_rx_status.addr_ok && i_rx_status.sof_ovr && bad)
        |=> st_q.cnt[IX_SOF] == $past(st_q.cnt[IX_SOF]) + 32'h1)
        else $error("overrun blocked by error");
    pause_mcast_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_tx_valid && i_tx_status.hw_pause)
        |=> st_q.cnt[IX_TXM] == $past(st_q.cnt[IX_TXM]) + 32'h1
            && st_q.cnt[IX_PAUSE] == $past(st_q.cnt[IX_PAUSE]) + 32'h1)
        else $error("pause not counted as multicast");
    pause_fdx_a: assert property (@(posedge i_clock) disable iff (i_srst)
        o_pause_send |-> st_q.fdx)
        else $error("pause sent in half duplex");
    dec_sat_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (st_q.done && st_q.wr && st_q.media_if_enable && st_q.addr[7:6] == 2'h0
            && i_hwdata == 32'hFFFFFFFF)
        |=> st_q.cnt[$past(st_q.addr[5:2])] == '0)
        else $error("decrement not saturated");
    direct_wr_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (st_q.done && st_q.wr && !st_q.media_if_enable && st_q.addr[7:6] == 2'h0)
        |=> st_q.cnt[$past(st_q.addr[5:2])] == $past(i_hwdata))
        else $error("direct write lost");
    irq_level_a: assert property (@(posedge i_clock) disable iff (i_srst)
        o_stats_irq_pending == (st_q.irq_en && top_bits != '0))
        else $error("interrupt level wrong");
    word_only_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (ap && i_hwrite && i_hsize != HSIZE_WORD) |=> !st_q.wr)
        else $error("sub-word write taken");
    tx_bad_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_tx_valid && !tx_good)
        |=> st_q.cnt[IX_TXG] == $past(st_q.cnt[IX_TXG]))
        else $error("bad transmit counted good");
    tx_bcast_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_tx_valid && tx_good && i_tx_status.bcast)
        |=> st_q.cnt[IX_TXB] == $past(st_q.cnt[IX_TXB]) + 32'h1)
        else $error("broadcast not counted");
    qos_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (quiet && i_rx_valid && i_rx_status.addr_ok && !st_q.rx_qos_filter_enable)
        |=> st_q.cnt[IX_QOS] == $past(st_q.cnt[IX_QOS]))
        else $error("qos drop counted while disabled");
    hold_zero_a: assert property (@(posedge i_clock) disable iff (i_srst)
        !st_q.done |-> st_q.cnt == '0)
        else $error("counter moved before clear done");

    good_rx_c: cover property (@(posedge i_clock) disable iff (i_srst)
        quiet && i_rx_valid && i_rx_status.addr_ok && inrng && !bad);
    pause_c: cover property (@(posedge i_clock) disable iff (i_srst)
        i_tx_valid && i_tx_status.hw_pause);
    decrement_c: cover property (@(posedge i_clock) disable iff (i_srst)
        st_q.wr && st_q.media_if_enable && st_q.addr[7:6] == 2'h0);
    irq_c: cover property (@(posedge i_clock) disable iff (i_srst) $rose(o_stats_irq_pending));
    discard_c: cover property (@(posedge i_clock) disable iff (i_srst)
        $rose(o_rx_code_discard));
endmodule
`default_nettype wire

// ==== inc/mfsc_pkg.sv ====
`default_nettype none
package mfsc_pkg;
    localparam int CW = 32;
    localparam int NCNT = 16;
    localparam int LW = 16;
    // counter word indices, byte address is four times the index
    localparam logic [3:0] IX_ALIGN = 4'h0;
    localparam logic [3:0] IX_LONG = 4'h1;
    localparam logic [3:0] IX_LBAD = 4'h2;
    localparam logic [3:0] IX_SHORT = 4'h3;
    localparam logic [3:0] IX_SBAD = 4'h4;
    localparam logic [3:0] IX_REJ = 4'h5;
    localparam logic [3:0] IX_QOS = 4'h6;
    localparam logic [3:0] IX_OCT = 4'h7;
    localparam logic [3:0] IX_SOF = 4'h8;
    localparam logic [3:0] IX_MOF = 4'h9;
    localparam logic [3:0] IX_DMA = 4'hA;
    localparam logic [3:0] IX_TXG = 4'hB;
    localparam logic [3:0] IX_TXB = 4'hC;
    localparam logic [3:0] IX_TXM = 4'hD;
    localparam logic [3:0] IX_PAUSE = 4'hE;
    localparam logic [3:0] IX_F64 = 4'hF;
    localparam logic [7:0] ADDR_MAC_CTRL = 8'h40;
    localparam logic [7:0] ADDR_RX_ACCEPT = 8'h44;
    localparam logic [7:0] ADDR_MAX_LEN = 8'h48;
    localparam logic [7:0] ADDR_STATUS = 8'h4C;
    localparam int MIF_BIT = 0;
    localparam int FDX_BIT = 1;
    localparam int IRQEN_BIT = 2;
    localparam int QOS_BIT = 0;
    localparam int PEND_BIT = 0;
    localparam int DONE_BIT = 1;
    localparam int CODE_BIT = 2;
    localparam logic [LW-1:0] MAX_LEN_RST = 16'h05EE;
    localparam logic [LW-1:0] MIN_LEN = 16'h0040;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLR_DELAY_CLK = 38;
    localparam logic [5:0] CLR_LAST = 6'(CLR_DELAY_CLK - 1);

    typedef struct packed {
        logic [LW-1:0] len;
        logic addr_ok;
        logic ctrl_frame;
        logic odd_nibbles;
        logic fcs_fail;
        logic fcs_fail_trunc;
        logic coll_fc_frag;
        logic sof_ovr;
        logic mof_ovr;
        logic dma_zero_hdp;
        logic [LW-1:0] flow_threshold;
        logic [LW-1:0] free_buffer_count;
    } mfsc_rx_status_s;

    typedef struct packed {
        logic [LW-1:0] len;
        logic late_coll;
        logic excess_coll;
        logic carrier_loss;
        logic underrun;
        logic bcast;
        logic mcast;
        logic hw_pause;
    } mfsc_tx_status_s;
endpackage
`default_nettype wire

// ==== verif/mfsc_far_mac.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfsc_far_mac
    import mfsc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // commands from the bench
    input wire logic i_go_rx,
    input wire mfsc_pkg::mfsc_rx_status_s i_rx_req,
    input wire logic i_bad_symbol,
    input wire logic i_go_tx,
    input wire mfsc_pkg::mfsc_tx_status_s i_tx_req,
    input wire logic i_slow,
    // toward the statistics block, except o_busy which goes back to the bench
    output logic o_rx_valid,
    output mfsc_pkg::mfsc_rx_status_s o_rx_status,
    output logic o_rx_active,
    output logic o_rx_error_input,
    output logic o_tx_valid,
    output mfsc_pkg::mfsc_tx_status_s o_tx_status,
    output logic o_busy
);
    logic [4:0] rx_left;
    logic [2:0] tx_left;
    assign o_busy = (rx_left != 5'h0) || (tx_left != 3'h0);
    always @(posedge i_clock)
    begin
        o_rx_valid <= 1'b0;
        o_tx_valid <= 1'b0;
        // idle status lines toggle so a stale value never looks valid
        o_rx_status <= ~o_rx_status;
        o_tx_status <= ~o_tx_status;
        // error pin held several clocks early in the frame, past the sync delay
        o_rx_error_input <= i_bad_symbol && (rx_left > 5'h3);
        if (i_srst)
        begin
            rx_left <= 5'h0;
            tx_left <= 3'h0;
            o_rx_active <= 1'b0;
            o_rx_status <= '0;
            o_tx_status <= '0;
        end
        else
        begin
            if (i_go_rx)
            begin
                rx_left <= i_slow ? 5'hE : 5'h6;
                o_rx_active <= 1'b1;
            end
            else if (rx_left != 5'h0)
            begin
                rx_left <= rx_left - 5'h1;
                if (rx_left == 5'h1)
                begin
                    o_rx_active <= 1'b0;
                    o_rx_valid <= 1'b1;
                    o_rx_status <= i_rx_req;
                end
            end
            if (i_go_tx)
                tx_left <= i_slow ? 3'h4 : 3'h1;
            else if (tx_left != 3'h0)
            begin
                tx_left <= tx_left - 3'h1;
                if (tx_left == 3'h1)
                begin
                    o_tx_valid <= 1'b1;
                    o_tx_status <= i_tx_req;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/mfsc_stats_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module mfsc_stats_tb_top;
    import mfsc_pkg::*;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic hsel = 1'b0, hwr = 1'b0, rd_ph = 1'b0;
    logic [2:0] hsz = HSIZE_WORD;
    logic [1:0] htr = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd;
    logic hrdy, hresp;
    logic go_rx = 1'b0, go_tx = 1'b0, bad = 1'b0, slow = 1'b0, preq = 1'b0;
    mfsc_rx_status_s rq = '0, rs;
    mfsc_tx_status_s tq = '0, ts;
    logic rv, ract, rerr, tv, busy, disc, psend, irq;
    logic [31:0] ec [16];
    logic [31:0] qr [$];
    logic qd [$];
    logic [31:0] gv;
    logic gd;
    logic [15:0] lens [8] = '{16'h0010, 16'h003F, 16'h0040, 16'h0041, 16'h007F, 16'h0080,
        16'h0081, 16'h0200};
    logic [15:0] maxl = MAX_LEN_RST;
    logic mif = 1'b0, qen = 1'b0;
    int n_mismatch = 0;
    int samples_checked = 0;
    integer seed = 32'h8428;
    initial forever #5 i_clock = ~i_clock;
    mfsc_stats i_mfsc_stats (.i_clock(i_clock), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(ha),
        .i_htrans(htr), .i_hwrite(hwr), .i_hsize(hsz), .i_hwdata(hwd), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrd), .i_rx_valid(rv), .i_rx_status(rs),
        .i_rx_active(ract), .i_rx_error_input(rerr), .o_rx_code_discard(disc),
        .i_tx_valid(tv), .i_tx_status(ts), .i_pause_req(preq), .o_pause_send(psend),
        .o_stats_irq_pending(irq));
    mfsc_far_mac i_mfsc_far_mac (.i_clock(i_clock), .i_srst(i_srst), .i_go_rx(go_rx),
        .i_rx_req(rq), .i_bad_symbol(bad), .i_go_tx(go_tx), .i_tx_req(tq), .i_slow(slow),
        .o_rx_valid(rv), .o_rx_status(rs), .o_rx_active(ract), .o_rx_error_input(rerr),
        .o_tx_valid(tv), .o_tx_status(ts), .o_busy(busy));
    always @(posedge i_clock)
    begin
        if (rd_ph && hrdy === 1'b1)
        begin
            gv = qr.pop_front();
            `CHK(hrd, gv)
            `CHK(hresp, 1'b0)
        end
        if (rv === 1'b1)
        begin
            gd = qd.pop_front();
            `CHK(disc, gd)
        end
    end
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge i_clock);
        hsel <= 1'b1;
        htr <= 2'h2;
        ha <= {24'h0, a};
        hwr <= w;
        do @(posedge i_clock); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htr <= 2'h0;
        hwd <= d;
        rd_ph <= ~w;
        do @(posedge i_clock); while (hrdy !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        qr.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic wc(input logic [3:0] i, input logic [31:0] d);
        ec[i] = mif ? ((ec[i] > d) ? ec[i] - d : 32'h0) : d;
        bus({2'h0, i, 2'h0}, 1'b1, d);
    endtask
    task automatic chk_all();
        for (int i = 0; i < 16; i++)
            rd(8'(i * 4), ec[i]);
    endtask
    task automatic settle();
        repeat (2) @(posedge i_clock);
        #1;
    endtask
    function automatic void inc(logic [3:0] i, logic c, logic [31:0] n = 32'h1);
        if (c)
            ec[i] += n;
    endfunction
    task automatic rx_frame();
        mfsc_rx_status_s s;
        logic b, crc, aln, er, ok, a;
        s = $bits(mfsc_rx_status_s)'({$random(seed), $random(seed)});
        s.len = lens[3'($random(seed))];
        s.flow_threshold = {12'h0, s.flow_threshold[3:0]};
        s.free_buffer_count = {12'h0, s.free_buffer_count[3:0]};
        b = 1'($random(seed));
        crc = !s.odd_nibbles && s.fcs_fail;
        aln = s.odd_nibbles && s.fcs_fail_trunc;
        er = crc || aln || b;
        ok = s.len >= MIN_LEN && s.len <= maxl;
        a = s.addr_ok;
        inc(IX_ALIGN, a && ok && (aln || b));
        inc(IX_LONG, a && s.len > maxl && !er);
        inc(IX_LBAD, a && s.len > maxl && er);
        inc(IX_SHORT, a && !s.ctrl_frame && s.len < MIN_LEN && !er);
        inc(IX_SBAD, !s.ctrl_frame && s.len < MIN_LEN && er && !s.coll_fc_frag);
        inc(IX_REJ, !a && !s.ctrl_frame && !er);
        inc(IX_QOS, a && ok && !er && qen && s.flow_threshold >= s.free_buffer_count);
        inc(IX_OCT, a && ok && !er, {16'h0, s.len});
        inc(IX_SOF, a && s.sof_ovr);
        inc(IX_MOF, a && s.mof_ovr && !s.sof_ovr);
        inc(IX_DMA, a && s.dma_zero_hdp);
        inc(IX_F64, a && s.len == MIN_LEN);
        qd.push_back(b);
        rq <= s;
        bad <= b;
        slow <= 1'($random(seed));
        go_rx <= 1'b1;
        @(posedge i_clock);
        go_rx <= 1'b0;
        @(posedge i_clock);
        while (busy) @(posedge i_clock);
    endtask
    task automatic tx_frame(input logic [1:0] m);
        mfsc_tx_status_s s;
        logic g;
        s = $bits(mfsc_tx_status_s)'($random(seed));
        if (m[1] || s.len[0])
            {s.late_coll, s.excess_coll, s.carrier_loss, s.underrun} = 4'h0;
        s.len = (m == 2'h1) ? MIN_LEN : lens[3'($random(seed))];
        s.hw_pause = m == 2'h1;
        if (m != 2'h0)
            {s.bcast, s.mcast} = (m == 2'h1) ? 2'h1 : ((m == 2'h3) ? 2'h2 : 2'h0);
        s.mcast = s.mcast && !s.bcast;
        g = !(s.late_coll || s.excess_coll || s.carrier_loss || s.underrun);
        inc(IX_TXG, g);
        inc(IX_TXB, g && s.bcast);
        inc(IX_TXM, (g && s.mcast) || s.hw_pause);
        inc(IX_PAUSE, s.hw_pause);
        inc(IX_F64, (g && s.len == MIN_LEN) || s.hw_pause);
        tq <= s;
        slow <= 1'($random(seed));
        go_tx <= 1'b1;
        @(posedge i_clock);
        go_tx <= 1'b0;
        @(posedge i_clock);
        while (busy) @(posedge i_clock);
    endtask
    initial
    begin
        foreach (ec[i])
            ec[i] = 32'h0;
        repeat (6) @(posedge i_clock);
        i_srst <= 1'b0;
        rd(ADDR_STATUS, 32'h0);
        bus({2'h0, IX_ALIGN, 2'h0}, 1'b1, 32'h5);
        repeat (40) @(posedge i_clock);
        rd(ADDR_STATUS, 32'h2);
        rd(ADDR_MAX_LEN, {16'h0, MAX_LEN_RST});
        rd(8'h50, 32'h0);
        chk_all();
        maxl = 16'h0080;
        bus(ADDR_MAX_LEN, 1'b1, 32'h80);
        for (int k = 0; k < 2; k++)
        begin
            qen = !qen;
            bus(ADDR_RX_ACCEPT, 1'b1, {31'h0, qen});
            repeat (40) rx_frame();
            repeat (15) tx_frame(2'h0);
            tx_frame(2'h1);
        end
        chk_all();
        mif = 1'b1;
        bus(ADDR_MAC_CTRL, 1'b1, 32'h1);
        wc(IX_OCT, 32'h10);
        wc(IX_SBAD, 32'hFFFFFFFF);
        mif = 1'b0;
        bus(ADDR_MAC_CTRL, 1'b1, 32'h4);
        wc(IX_TXG, 32'h7FFFFFFF);
        settle();
        `CHK(irq, 1'b0)
        tx_frame(2'h2);
        settle();
        `CHK(irq, 1'b1)
        rd(ADDR_STATUS, 32'h3);
        mif = 1'b1;
        bus(ADDR_MAC_CTRL, 1'b1, 32'h5);
        wc(IX_TXG, 32'h1);
        settle();
        `CHK(irq, 1'b0)
        mif = 1'b0;
        bus(ADDR_MAC_CTRL, 1'b1, 32'h0);
        hsz <= 3'h0;
        bus({2'h0, IX_REJ, 2'h0}, 1'b1, 32'h0);
        hsz <= HSIZE_WORD;
        wc(IX_TXB, 32'hFFFFFFFF);
        tx_frame(2'h3);
        chk_all();
        preq <= 1'b1;
        settle();
        `CHK(psend, 1'b0)
        bus(ADDR_MAC_CTRL, 1'b1, 32'h2);
        settle();
        `CHK(psend, 1'b1)
        rd(ADDR_MAC_CTRL, 32'h2);
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
